// ===== inc/sram_port_pkg.sv
// shared constants and types of the pipelined burst sram port
package sram_port_pkg;

    // ------------------------------------------------------------
    // organisation
    // ------------------------------------------------------------
    localparam int ADDR_W     = 20;
    localparam int ROW_W      = 19;
    localparam int DATA_W     = 36;
    localparam int HALF_W     = 18;
    localparam int LANE_W     = 9;
    localparam int LANES      = 4;
    localparam int HALF_LANES = 2;
    localparam int ROWS       = 1 << ROW_W;

    // ------------------------------------------------------------
    // burst counter
    // ------------------------------------------------------------
    localparam int              BURST_W    = 2;
    localparam logic [1:0]      BURST_STEP = 2'h1;
    localparam logic [1:0]      BURST_RST  = 2'h0;

    // ------------------------------------------------------------
    // encodings and reset values
    // ------------------------------------------------------------
    localparam logic              RW_READ    = 1'h1;
    localparam logic              ORDER_INTL = 1'h1;
    localparam int                HALF_SEL   = 0;
    localparam logic [3:0]        LANES_OFF  = 4'hf;
    localparam logic [1:0]        HALF_OFF   = 2'h3;
    localparam logic [19:0]       ADDR_RST   = 20'h00000;
    localparam logic [35:0]       DATA_RST   = 36'h000000000;
    localparam logic [17:0]       HALF_ZERO  = 18'h00000;

    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } op_type;

    typedef enum logic {
        BURST_IDLE = 1'b0,
        BURST_RUN  = 1'b1
    } burst_state_type;

endpackage

// ===== inc/burst_step_if.sv
// carrier between the burst sequencer and the port control
`timescale 1ns/1ps
`default_nettype none

interface burst_step_if;
    logic [1:0] base;
    logic [1:0] count;
    logic       interleave;
    logic [1:0] low;

    modport seq (
        input  base,
        input  count,
        input  interleave,
        output low
    );

    modport user (
        output base,
        output count,
        output interleave,
        input  low
    );
endinterface

`default_nettype wire

// ===== rtl/burst_sequencer.sv
// low address bits of a burst step, linear or interleaved
`timescale 1ns/1ps
`default_nettype none

module burst_sequencer
    import sram_port_pkg::*;
(
    burst_step_if.seq step_bus
);

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    always_comb begin
        if (step_bus.interleave == ORDER_INTL) begin
            step_bus.low = step_bus.base ^ step_bus.count;
        end else begin
            step_bus.low = step_bus.base + step_bus.count;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/byte_lane_merge.sv
// one byte lane of a word write, kept or replaced
`timescale 1ns/1ps
`default_nettype none

module byte_lane_merge #(
    parameter int W = 9
) (
    input  wire logic [W-1:0] old_in,
    input  wire logic [W-1:0] new_in,
    input  wire logic         write_n_in,
    output logic      [W-1:0] lane_out
);

    // ------------------------------------------------------------
    // select
    // ------------------------------------------------------------
    // per lane select
    assign lane_out = write_n_in ? old_in : new_in;

endmodule

`default_nettype wire

// ===== rtl/pipelined_burst_sram_port.sv
// synchronous control, burst counter and array of a pipelined burst sram
`timescale 1ns/1ps
`default_nettype none

module pipelined_burst_sram_port
    import sram_port_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              rst_n_in,
    input  wire logic              organisation_x18_in,
    input  wire logic [ADDR_W-1:0] word_address_in,
    input  wire logic              chip_select_low_a_n_in,
    input  wire logic              chip_select_low_b_n_in,
    input  wire logic              chip_select_high_in,
    input  wire logic              read_write_in,
    input  wire logic              advance_or_load_in,
    input  wire logic              clock_hold_n_in,
    input  wire logic [LANES-1:0]  byte_write_n_in,
    input  wire logic              burst_order_select_in,
    input  wire logic              output_drive_n_in,
    input  wire logic              sleep_request_in,
    input  wire logic [DATA_W-1:0] data_bus_in,
    output logic      [DATA_W-1:0] data_bus_out,
    output logic                   data_bus_oe_out,
    output logic                   sleeping_out
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic                run;
    logic                chip_selected;
    logic                load_cycle;
    logic                deselect_cycle;
    logic                advance_cycle;

    burst_state_type     burst_state_r;
    op_type              burst_op_r;
    logic [ADDR_W-1:0]   base_addr_r;
    logic [BURST_W-1:0]  burst_cnt_r;

    op_type              issue_op;
    logic [ADDR_W-1:0]   issue_addr;
    logic [LANES-1:0]    issue_bw_n;

    op_type              s1_op_r;
    logic [ADDR_W-1:0]   s1_addr_r;
    logic [LANES-1:0]    s1_bw_n_r;
    op_type              s2_op_r;
    logic [ADDR_W-1:0]   s2_addr_r;
    logic [LANES-1:0]    s2_bw_n_r;

    logic [ROW_W-1:0]    s1_row;
    logic [ROW_W-1:0]    s2_row;
    logic [DATA_W-1:0]   old_word;
    logic [DATA_W-1:0]   wdata_word;
    logic [LANES-1:0]    lane_write_n;
    logic [DATA_W-1:0]   merged_word;
    logic [DATA_W-1:0]   read_word;
    logic [DATA_W-1:0]   read_data;

    logic [DATA_W-1:0]   data_out_r;
    logic                drive_r;
    logic                sleep_r;

    logic [DATA_W-1:0]   mem_array [0:ROWS-1];

    burst_step_if        step_bus ();

    // ------------------------------------------------------------
    // row of an address in either organisation
    // ------------------------------------------------------------
    function automatic logic [ROW_W-1:0] row_of(
        input logic [ADDR_W-1:0] addr,
        input logic              x18
    );
        logic [ROW_W-1:0] row;
        if (x18) begin
            row = addr[ADDR_W-1:1];
        end else begin
            row = addr[ROW_W-1:0];
        end
        return row;
    endfunction

    // ------------------------------------------------------------
    // cycle decode
    // ------------------------------------------------------------
    // hold gates all
    assign run = ~clock_hold_n_in;

    assign chip_selected = ~chip_select_low_a_n_in
                         & ~chip_select_low_b_n_in
                         & chip_select_high_in;

    assign load_cycle = run
                      & ~advance_or_load_in
                      & chip_selected
                      & ~sleep_r;

    assign deselect_cycle = run
                          & ~advance_or_load_in
                          & ~(chip_selected & ~sleep_r);

    assign advance_cycle = run
                         & advance_or_load_in
                         & (burst_state_r == BURST_RUN)
                         & ~sleep_r;

    // ------------------------------------------------------------
    // burst sequencer
    // ------------------------------------------------------------
    assign step_bus.base = base_addr_r[BURST_W-1:0];
    assign step_bus.count = burst_cnt_r + BURST_STEP;
    assign step_bus.interleave = burst_order_select_in;

    burst_sequencer u_burst_sequencer (
        .step_bus (step_bus)
    );

    // ------------------------------------------------------------
    // burst state
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            burst_state_r <= BURST_IDLE;
            burst_op_r    <= OP_IDLE;
            base_addr_r   <= ADDR_RST;
            burst_cnt_r   <= BURST_RST;
        end else if (run) begin
            case (burst_state_r)
                BURST_IDLE: begin
                    if (load_cycle) begin
                        burst_state_r <= BURST_RUN;
                        burst_op_r    <= issue_op;
                        base_addr_r   <= word_address_in;
                        burst_cnt_r   <= BURST_RST;
                    end
                end
                BURST_RUN: begin
                    if (load_cycle) begin
                        burst_op_r  <= issue_op;
                        base_addr_r <= word_address_in;
                        burst_cnt_r <= BURST_RST;
                    end else if (deselect_cycle || sleep_r) begin
                        burst_state_r <= BURST_IDLE;
                        burst_op_r    <= OP_IDLE;
                    end else if (advance_cycle) begin
                        burst_cnt_r <= burst_cnt_r + BURST_STEP;
                    end
                end
                default: begin
                    burst_state_r <= BURST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // operation issued this edge
    // ------------------------------------------------------------
    always_comb begin
        issue_op   = OP_IDLE;
        issue_addr = base_addr_r;
        issue_bw_n = LANES_OFF;
        if (load_cycle) begin
            if (read_write_in == RW_READ) begin
                issue_op = OP_READ;
            end else begin
                issue_op   = OP_WRITE;
                issue_bw_n = byte_write_n_in;
            end
            issue_addr = word_address_in;
        end else if (advance_cycle) begin
            issue_op   = burst_op_r;
            issue_addr = {base_addr_r[ADDR_W-1:BURST_W], step_bus.low};
            if (burst_op_r == OP_WRITE) begin
                issue_bw_n = byte_write_n_in;
            end
        end
    end

    // ------------------------------------------------------------
    // pipeline stages
    // ------------------------------------------------------------
    // registered inputs
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            s1_op_r   <= OP_IDLE;
            s1_addr_r <= ADDR_RST;
            s1_bw_n_r <= LANES_OFF;
            s2_op_r   <= OP_IDLE;
            s2_addr_r <= ADDR_RST;
            s2_bw_n_r <= LANES_OFF;
        end else if (run) begin
            s1_op_r   <= issue_op;
            s1_addr_r <= issue_addr;
            s1_bw_n_r <= issue_bw_n;
            s2_op_r   <= s1_op_r;
            s2_addr_r <= s1_addr_r;
            s2_bw_n_r <= s1_bw_n_r;
        end
    end

    assign s1_row = row_of(s1_addr_r, organisation_x18_in);
    assign s2_row = row_of(s2_addr_r, organisation_x18_in);

    // ------------------------------------------------------------
    // write data and lane selects
    // ------------------------------------------------------------
    always_comb begin
        if (organisation_x18_in) begin
            wdata_word = {data_bus_in[HALF_W-1:0], data_bus_in[HALF_W-1:0]};
            if (s2_addr_r[HALF_SEL]) begin
                lane_write_n = {s2_bw_n_r[HALF_LANES-1:0], HALF_OFF};
            end else begin
                lane_write_n = {HALF_OFF, s2_bw_n_r[HALF_LANES-1:0]};
            end
        end else begin
            wdata_word   = data_bus_in;
            lane_write_n = s2_bw_n_r;
        end
    end

    assign old_word = mem_array[s2_row];

    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane++) begin : g_lane
            byte_lane_merge #(
                .W (LANE_W)
            ) u_byte_lane_merge (
                .old_in     (old_word[lane*LANE_W +: LANE_W]),
                .new_in     (wdata_word[lane*LANE_W +: LANE_W]),
                .write_n_in (lane_write_n[lane]),
                .lane_out   (merged_word[lane*LANE_W +: LANE_W])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // array write
    // ------------------------------------------------------------
    // write two cycles on
    always_ff @(posedge clk_sys_in) begin
        if (rst_n_in && run && (s2_op_r == OP_WRITE)) begin
            mem_array[s2_row] <= merged_word;
        end
    end

    // ------------------------------------------------------------
    // array read
    // ------------------------------------------------------------
    always_comb begin
        if ((s2_op_r == OP_WRITE) && (s2_row == s1_row)) begin
            read_word = merged_word;
        end else begin
            read_word = mem_array[s1_row];
        end
        if (!organisation_x18_in) begin
            read_data = read_word;
        end else if (s1_addr_r[HALF_SEL]) begin
            read_data = {HALF_ZERO, read_word[DATA_W-1:HALF_W]};
        end else begin
            read_data = {HALF_ZERO, read_word[HALF_W-1:0]};
        end
    end

    // ------------------------------------------------------------
    // output register and drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            data_out_r <= DATA_RST;
            drive_r    <= 1'h0;
        end else if (run) begin
            drive_r <= (s1_op_r == OP_READ);
            if (s1_op_r == OP_READ) begin
                data_out_r <= read_data;
            end
        end
    end

    // ------------------------------------------------------------
    // sleep
    // ------------------------------------------------------------
    // sampled sleep
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sleep_r <= 1'h0;
        end else if (run) begin
            sleep_r <= sleep_request_in;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign data_bus_out = data_out_r;
    assign data_bus_oe_out = drive_r & ~output_drive_n_in;
    assign sleeping_out = sleep_r;

endmodule

`default_nettype wire

// ===== verif/sram_port_properties.sv
// pin-level assertions of the pipelined burst sram port
`timescale 1ns/1ps
`default_nettype none

module sram_port_properties
    import sram_port_pkg::*;
(
    input wire logic              clk_sys_in,
    input wire logic              rst_n_in,
    input wire logic              chip_select_low_a_n_in,
    input wire logic              chip_select_low_b_n_in,
    input wire logic              chip_select_high_in,
    input wire logic              read_write_in,
    input wire logic              advance_or_load_in,
    input wire logic              clock_hold_n_in,
    input wire logic              output_drive_n_in,
    input wire logic              sleep_request_in,
    input wire logic [DATA_W-1:0] data_bus_out,
    input wire logic              data_bus_oe_out,
    input wire logic              sleeping_out
);
    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire logic take = !clock_hold_n_in;
    wire logic sel  = !chip_select_low_a_n_in && !chip_select_low_b_n_in && chip_select_high_in;
    wire logic load = take && !advance_or_load_in && sel && !sleeping_out;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    a_gate_forces_off:
        assert property (output_drive_n_in |-> !data_bus_oe_out) else $error("drive gate did not float bus");
    a_read_two_later:
        assert property (load && read_write_in ##1 take |-> ##1 (data_bus_oe_out || output_drive_n_in))
        else $error("read data not driven two cycles on");
    a_write_floats:
        assert property (load && !read_write_in ##1 take |-> ##1 !data_bus_oe_out)
        else $error("bus driven in write data cycle");
    a_deselect_floats:
        assert property (take && !advance_or_load_in && !sel ##1 take |-> ##1 !data_bus_oe_out)
        else $error("bus driven two cycles after deselect");
    a_hold_freezes:
        assert property (clock_hold_n_in |=> $stable(data_bus_out) && $stable(sleeping_out))
        else $error("outputs moved on a held edge");
    a_sleep_follows:
        assert property (take |=> sleeping_out == $past(sleep_request_in)) else $error("sleep state wrong");
    a_sleep_blocks_load:
        assert property (take && sleeping_out && !advance_or_load_in ##1 take |-> ##1 !data_bus_oe_out)
        else $error("load accepted while sleeping");
    a_burst_read_run:
        assert property (load && read_write_in ##1 (take && advance_or_load_in && !sleeping_out) [*3]
            |-> ##1 (data_bus_oe_out || output_drive_n_in)) else $error("burst read word missing");
endmodule

bind pipelined_burst_sram_port sram_port_properties u_props (
    .clk_sys_in, .rst_n_in, .chip_select_low_a_n_in, .chip_select_low_b_n_in, .chip_select_high_in,
    .read_write_in, .advance_or_load_in, .clock_hold_n_in, .output_drive_n_in, .sleep_request_in,
    .data_bus_out, .data_bus_oe_out, .sleeping_out);

`default_nettype wire

// ===== verif/sram_controller_model.sv
// memory controller model: drives write data onto the bus in the data cycle
`timescale 1ns/1ps
`default_nettype none

module sram_controller_model
    import sram_port_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              rst_n_in,
    input  wire logic              clock_hold_n_in,
    input  wire logic              advance_or_load_in,
    input  wire logic              read_write_in,
    input  wire logic              chip_select_low_a_n_in,
    input  wire logic              chip_select_low_b_n_in,
    input  wire logic              chip_select_high_in,
    input  wire logic              sleeping_in,
    input  wire logic [DATA_W-1:0] write_data_in,
    output logic      [DATA_W-1:0] data_bus_out
);
    logic              wburst_r;
    logic              wr1_r;
    logic              wr2_r;
    logic [DATA_W-1:0] d1_r;
    logic [DATA_W-1:0] d2_r;
    logic [DATA_W-1:0] last_r;
    wire  logic        ld = !advance_or_load_in && !chip_select_low_a_n_in && !chip_select_low_b_n_in
                            && chip_select_high_in && !sleeping_in;

    // write data two cycles on, frozen by hold
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            wburst_r <= 1'h0;
            wr1_r    <= 1'h0;
            wr2_r    <= 1'h0;
        end else if (!clock_hold_n_in) begin
            if (!advance_or_load_in) begin
                wburst_r <= ld && !read_write_in;
            end
            wr1_r <= ld ? !read_write_in : (advance_or_load_in && wburst_r && !sleeping_in);
            d1_r  <= write_data_in;
            wr2_r <= wr1_r;
            d2_r  <= d1_r;
        end
    end

    // released bus shows a changing pattern, never the last value
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            last_r <= DATA_RST;
        end else begin
            last_r <= data_bus_out;
        end
    end

    assign data_bus_out = wr2_r ? d2_r : ~last_r;
endmodule

`default_nettype wire

// ===== verif/pipelined_burst_sram_port_tb.sv
// self-checking bench of the pipelined burst sram port
`timescale 1ns/1ps
`default_nettype none

module pipelined_burst_sram_port_tb
    import sram_port_pkg::*;
;
    logic clk_sys_in = 1'h0, rst_n_in = 1'h0, organisation_x18_in = 1'h0, chip_select_low_a_n_in = 1'h1;
    logic chip_select_low_b_n_in = 1'h1, chip_select_high_in = 1'h0, read_write_in = 1'h1;
    logic advance_or_load_in = 1'h0, clock_hold_n_in = 1'h0, burst_order_select_in = 1'h0;
    logic output_drive_n_in = 1'h0, sleep_request_in = 1'h0;
    logic [ADDR_W-1:0] word_address_in = ADDR_RST;
    logic [LANES-1:0]  byte_write_n_in = LANES_OFF;
    logic [DATA_W-1:0] write_data = DATA_RST;
    logic [DATA_W-1:0] data_bus_in, data_bus_out, s1_d, p_d, o_d;
    logic              data_bus_oe_out, sleeping_out, h_last, s1_rd, p_rd, o_rd, slp, sleep_last;
    logic              csa, csb, csh, gate, slq;
    int                fails = 0;
    int                cmp_count = 0;

    localparam logic [35:0] VA = 36'h123456789, VB = 36'hfedcba987, VC = 36'h0f0f0f0f0, KEEP = 36'hff803fe00;
    localparam logic [35:0] VM = (VA & KEEP) | (VB & ~KEEP);
    typedef struct packed {logic rw; logic [19:0] a; logic [3:0] bw; logic [35:0] wd; logic [35:0] ex;} row_type;
    row_type rows [8] = '{'{1'h0, 20'h00010, 4'h0, VA, DATA_RST}, '{1'h0, 20'h00011, 4'h0, VB, DATA_RST},
        '{1'h1, 20'h00010, 4'h0, DATA_RST, VA}, '{1'h0, 20'h00012, 4'h0, VC, DATA_RST},
        '{1'h1, 20'h00011, 4'h0, DATA_RST, VB}, '{1'h0, 20'h00010, 4'ha, VB, DATA_RST},
        '{1'h1, 20'h00010, 4'h0, DATA_RST, VM}, '{1'h1, 20'h00012, 4'h0, DATA_RST, VC}};

    pipelined_burst_sram_port dut (.clk_sys_in, .rst_n_in, .organisation_x18_in, .word_address_in,
        .chip_select_low_a_n_in, .chip_select_low_b_n_in, .chip_select_high_in, .read_write_in,
        .advance_or_load_in, .clock_hold_n_in, .byte_write_n_in, .burst_order_select_in, .output_drive_n_in,
        .sleep_request_in, .data_bus_in, .data_bus_out, .data_bus_oe_out, .sleeping_out);

    sram_controller_model partner (.clk_sys_in, .rst_n_in, .clock_hold_n_in, .advance_or_load_in, .read_write_in,
        .chip_select_low_a_n_in, .chip_select_low_b_n_in, .chip_select_high_in, .sleeping_in(sleeping_out),
        .write_data_in(write_data), .data_bus_out(data_bus_in));

    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    function automatic logic [DATA_W-1:0] dw(input logic [1:0] i);
        return {34'h2c0de1234, i};
    endfunction

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        if (fails == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one command cycle; checks the bus outputs of the command two taken edges back and sleeping_out of the one taken edge back
    task automatic cyc(input logic h, adv, rw, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bw,
                       input logic [DATA_W-1:0] wd, input logic rd, input logic [DATA_W-1:0] ex);
        @(posedge clk_sys_in);
        clock_hold_n_in <= h;
        advance_or_load_in <= adv;
        read_write_in <= rw;
        word_address_in <= a;
        byte_write_n_in <= bw;
        write_data <= wd;
        chip_select_low_a_n_in <= csa;
        chip_select_low_b_n_in <= csb;
        chip_select_high_in <= csh;
        output_drive_n_in <= gate;
        sleep_request_in <= slq;
        #1;
        if (!h_last) begin
            o_rd = s1_rd;
            o_d = s1_d;
            s1_rd = p_rd;
            s1_d = p_d;
            slp = sleep_last;
        end
        chk(data_bus_oe_out, o_rd & ~gate);
        if (o_rd) chk(data_bus_out, o_d);
        chk(sleeping_out, slp);
        h_last = h;
        p_rd = rd;
        p_d = ex;
        sleep_last = slq;
    endtask

    task automatic idl(input int n);
        csh = 1'h0;
        repeat (n) cyc(1'h0, 1'h0, 1'h1, ADDR_RST, LANES_OFF, DATA_RST, 1'h0, DATA_RST);
        csh = 1'h1;
    endtask

    // burst order only changes under reset
    task automatic rst(input logic x18, input logic order);
        repeat (20) begin
            @(posedge clk_sys_in);
            rst_n_in <= 1'h0;
            organisation_x18_in <= x18;
            burst_order_select_in <= order;
            chip_select_high_in <= 1'h0;
            advance_or_load_in <= 1'h0;
            sleep_request_in <= 1'h0;
        end
        @(posedge clk_sys_in);
        rst_n_in <= 1'h1;
        #1;
        chk(data_bus_oe_out, 1'h0);
        chk(data_bus_out, DATA_RST);
        {h_last, s1_rd, p_rd, o_rd, slp, sleep_last, csa, csb, gate, slq, csh} = 11'h001;
    endtask

    initial begin
        #(8 * 20000);
        fails++;
        results();
    end

    initial begin
        rst(1'h0, 1'h0);
        foreach (rows[i]) cyc(1'h0, 1'h0, rows[i].rw, rows[i].a, rows[i].bw, rows[i].wd, rows[i].rw, rows[i].ex);
        idl(2);
        // linear write burst at 102, read burst at 103, address pins scrambled
        for (int n = 0; n < 4; n++) cyc(1'h0, n != 0, 1'h0, n ? 20'hfffff : 20'h00102, 4'h0, dw(2'(n)), 1'h0, DATA_RST);
        for (int n = 0; n < 4; n++) cyc(1'h0, n != 0, 1'h1, n ? ADDR_RST : 20'h00103, 4'h0, DATA_RST, 1'h1, dw(2'(n + 1)));
        idl(2);
        // each select alone deselects, then advance is a nop
        for (int i = 0; i < 3; i++) begin
            cyc(1'h0, 1'h0, 1'h1, 20'h00012, 4'h0, DATA_RST, 1'h1, VC);
            csa = (i == 0);
            csb = (i == 1);
            csh = (i != 2);
            cyc(1'h0, 1'h0, 1'h1, 20'h00010, 4'h0, DATA_RST, 1'h0, DATA_RST);
            {csa, csb, csh} = 3'h1;
            cyc(1'h0, 1'h1, 1'h1, 20'h00010, 4'h0, DATA_RST, 1'h0, DATA_RST);
        end
        // gate floats a read for its whole data cycle
        cyc(1'h0, 1'h0, 1'h1, 20'h00010, 4'h0, DATA_RST, 1'h1, VM);
        idl(1);
        gate = 1'h1;
        idl(1);
        gate = 1'h0;
        idl(1);
        // interleaved read burst at 101 with held edges carrying a write load
        rst(1'h0, 1'h1);
        for (int n = 0; n < 4; n++) begin
            if (n == 2) repeat (2) cyc(1'h1, 1'h0, 1'h0, 20'h00100, 4'h0, VA, 1'h0, DATA_RST);
            cyc(1'h0, n != 0, 1'h1, n ? ADDR_RST : 20'h00101, 4'h0, DATA_RST, 1'h1, dw(2'((1 ^ n) + 2)));
        end
        idl(2);
        // a load while sleeping is a deselect
        slq = 1'h1;
        idl(1);
        cyc(1'h0, 1'h0, 1'h1, 20'h00010, 4'h0, DATA_RST, 1'h0, DATA_RST);
        slq = 1'h0;
        idl(2);
        cyc(1'h0, 1'h0, 1'h1, 20'h00010, 4'h0, DATA_RST, 1'h1, VM);
        idl(2);
        // by-18 halves of one row, partial lane write
        rst(1'h1, 1'h0);
        cyc(1'h0, 1'h0, 1'h0, 20'h80020, 4'hc, {HALF_ZERO, 18'h2a5a5}, 1'h0, DATA_RST);
        cyc(1'h0, 1'h0, 1'h0, 20'h80021, 4'hc, {HALF_ZERO, 18'h15a5a}, 1'h0, DATA_RST);
        cyc(1'h0, 1'h0, 1'h0, 20'h80021, 4'he, {HALF_ZERO, 18'h00033}, 1'h0, DATA_RST);
        cyc(1'h0, 1'h0, 1'h1, 20'h80020, 4'h0, DATA_RST, 1'h1, {HALF_ZERO, 18'h2a5a5});
        cyc(1'h0, 1'h0, 1'h1, 20'h80021, 4'h0, DATA_RST, 1'h1, {HALF_ZERO, (18'h15a5a & 18'h3fe00) | 18'h00033});
        idl(2);
        results();
    end
endmodule

`default_nettype wire
